/* File: logic/aes_ahb_slave.sv */
// ahb-lite slave front end with one wait state on every transfer
`timescale 1ns/10ps
`default_nettype none
module aes_ahb_slave
	import aes_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        reset,
	input  wire logic        clk_en,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic        hready,
	input  wire logic [31:0] hwdata,
	output logic             hreadyout,
	output logic             hresp,
	output logic      [31:0] hrdata,
	aes_reg_if.slave         rb
);
	logic        pend;
	logic        pend_wr;
	logic        pend_map;
	logic [11:0] pend_idx;
	logic        addr_ok;

	// word aligned, inside the bank's index range
	assign addr_ok = (haddr[1:0] == 2'h0) && (haddr[31:14] == 18'h00000)
		&& (haddr[13:2] >= IDX_MAC_1) && (haddr[13:2] <= IDX_CTRL);

	// address phase taken, then one wait cycle in which data is moved
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			pend      <= 1'b0;
			pend_wr   <= 1'b0;
			pend_map  <= 1'b0;
			pend_idx  <= 12'h000;
			hreadyout <= 1'b1;
			hrdata    <= 32'h00000000;
		end else if (clk_en) begin
			if (pend) begin
				pend      <= 1'b0;
				hreadyout <= 1'b1;
				// unmapped or write data phases return zero
				hrdata    <= (pend_map && !pend_wr) ?
					{24'h000000, rb.rdata} : 32'h00000000;
			end else if (hsel && hready && htrans[1]) begin
				pend      <= 1'b1;
				pend_wr   <= hwrite;
				pend_map  <= addr_ok;
				pend_idx  <= haddr[13:2];
				hreadyout <= 1'b0;
			end
		end
	end

	// the response is always okay
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			hresp <= 1'b0;
		end else if (clk_en) begin
			hresp <= 1'b0;
		end
	end

	// write strobe lasts the single wait cycle while hwdata stands
	assign rb.wr    = clk_en && pend && pend_wr && pend_map;
	assign rb.idx   = pend_idx;
	assign rb.wdata = hwdata[7:0];
endmodule
`default_nettype wire

/* File: logic/aes_pkg.sv */
// shared constants and types for the acl entry staging register bank
package aes_pkg;
	localparam int unsigned AES_DEPTH      = 16;
	localparam int unsigned AES_BYTES      = 16;
	localparam int unsigned AES_STAGE_BASE = 6;
	localparam int unsigned AES_UPPER_N    = 6;
	// register indices; the byte address is four times the index
	localparam logic [11:0] IDX_MAC_1      = 12'h606;
	localparam logic [11:0] IDX_MAC_0      = 12'h607;
	localparam logic [11:0] IDX_ETYPE_HI   = 12'h608;
	localparam logic [11:0] IDX_ETYPE_LO   = 12'h609;
	localparam logic [11:0] IDX_PRIO_ACT   = 12'h60a;
	localparam logic [11:0] IDX_REMARK_MAP = 12'h60b;
	localparam logic [11:0] IDX_SPARE      = 12'h60c;
	localparam logic [11:0] IDX_FWD_PORTS  = 12'h60d;
	localparam logic [11:0] IDX_RULESET_HI = 12'h60e;
	localparam logic [11:0] IDX_RULESET_LO = 12'h60f;
	localparam logic [11:0] IDX_BE_HIGH    = 12'h610;
	localparam logic [11:0] IDX_BE_LOW_GO  = 12'h611;
	localparam logic [11:0] IDX_CTRL       = 12'h612;
	// reset values
	localparam logic [7:0]  RST_BYTE       = 8'h00;
	localparam logic [4:0]  RST_CTRL_RW    = 5'h00;
	localparam logic        RST_DONE       = 1'b1;
	// control register fields
	localparam int unsigned CTRL_WDONE     = 6;
	localparam int unsigned CTRL_RDONE     = 5;
	localparam int unsigned CTRL_DIR       = 4;
	localparam int unsigned CTRL_IDX_MSB   = 3;
	// entry byte numbers and field positions used by the lookup port
	localparam int unsigned BYTE_PRIO_ACT  = 10;
	localparam int unsigned BYTE_REMARK    = 11;
	localparam int unsigned BYTE_FWD       = 13;
	localparam int unsigned PM_MSB         = 7;
	localparam int unsigned PM_LSB         = 6;
	localparam int unsigned RPE_BIT        = 2;
	localparam int unsigned REM_HI_MSB     = 1;
	localparam int unsigned REM_LO_BIT     = 7;
	localparam int unsigned MM_MSB         = 6;
	localparam int unsigned MM_LSB         = 5;
	localparam int unsigned FWD_MSB        = 6;
	typedef enum logic [1:0] {
		AES_ST_IDLE = 2'b01,
		AES_ST_XFER = 2'b10
	} aes_state_e;
endpackage

/* File: logic/aes_reg_if.sv */
// register access channel between the bus slave and the register bank
`timescale 1ns/10ps
`default_nettype none
interface aes_reg_if;
	logic        wr;
	logic [11:0] idx;
	logic [7:0]  wdata;
	logic [7:0]  rdata;
	modport slave (output wr, output idx, output wdata, input rdata);
	modport bank  (input wr, input idx, input wdata, output rdata);
endinterface
`default_nettype wire

/* File: logic/aes_regs.sv */
// acl entry staging registers with indirect access to the per-port table
//
// Notes on behaviour
// [RULE_01] The 3-bit remark priority is bits 1:0 of byte A above bit 7 of byte B.
// [RULE_02] The 7-bit forward map gives one bit per port, bit 0 for port 1, set means forward.
// [RULE_03] Writing the low byte-enable register starts a transfer with the full 16-bit mask.
// [RULE_04] High byte-enable bit 0 selects access byte 7 down to bit 7 selecting byte 0.
// [RULE_05] Low byte-enable bit 0 selects access byte F down to bit 7 selecting byte 8.
// [RULE_06] A set enable bit takes part in the transfer and a clear one stays out of it.
// [RULE_07] Write status reads low while an entry write runs and high when done; bit 4 gives direction and bits 3:0 the index.
// [RULE_08] Software polls read status until it is one before reading results.
// [RULE_09] Disabled table bytes keep their value on a write, disabled staging bytes on a read.
`timescale 1ns/10ps
`default_nettype none
module aes_regs
	import aes_pkg::*;
#(
	parameter int unsigned DEPTH = AES_DEPTH
) (
	input  wire logic        clk,
	input  wire logic        reset,
	input  wire logic        clk_en,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic        hready,
	input  wire logic [31:0] hwdata,
	output logic             hreadyout,
	output logic             hresp,
	output logic      [31:0] hrdata,
	input  wire logic [47:0] upper_stage_in,
	output logic      [47:0] upper_stage_out,
	output logic      [5:0]  upper_stage_load,
	input  wire logic [3:0]  lookup_index,
	output logic      [1:0]  priority_handling_select,
	output logic             remark_priority_enable,
	output logic      [2:0]  remark_priority,
	output logic      [1:0]  forward_map_handling,
	output logic      [6:0]  forward_map
);
	aes_reg_if  rb ();
	aes_state_e state;
	logic [7:0] stage [AES_STAGE_BASE:AES_BYTES-1];
	logic [7:0] entry [AES_BYTES];
	logic [7:0] tbl   [DEPTH][AES_BYTES];
	logic [7:0] be_high;
	logic [7:0] be_low;
	logic       ctrl_dir;
	logic [3:0] ctrl_idx;
	logic       wr_done;
	logic       rd_done;
	logic       xfer_dir;
	logic [3:0] xfer_idx;
	logic [15:0] xfer_mask;
	logic       trig;
	logic       in_xfer;
	logic [7:0] lk_prio;
	logic [7:0] lk_remark;
	logic [7:0] lk_fwd;

	// bus front end; hsize is accepted but only word transfers are used
	aes_ahb_slave u_bus (
		.clk       (clk),
		.reset     (reset),
		.clk_en    (clk_en),
		.hsel      (hsel),
		.haddr     (haddr),
		.htrans    (htrans),
		.hwrite    (hwrite),
		.hready    (hready),
		.hwdata    (hwdata),
		.hreadyout (hreadyout),
		.hresp     (hresp),
		.hrdata    (hrdata),
		.rb        (rb)
	);

	// a start while a transfer runs is dropped, the mask still updates
	assign trig    = rb.wr && (rb.idx == IDX_BE_LOW_GO)
		&& (state == AES_ST_IDLE); // [RULE_03]
	assign in_xfer = clk_en && (state == AES_ST_XFER);

	// staging bytes 6 to F; a table read loads only enabled bytes
	for (genvar r = AES_STAGE_BASE; r < AES_BYTES; r++) begin : g_stage
		aes_stage_byte #(
			.RESET_VALUE (RST_BYTE)
		) u_byte (
			.clk     (clk),
			.reset   (reset),
			.clk_en  (clk_en),
			.sw_we   (rb.wr && (rb.idx == IDX_MAC_1
				+ 12'(r - AES_STAGE_BASE))),
			.sw_data (rb.wdata),
			.ld_en   ((state == AES_ST_XFER) && !xfer_dir
				&& xfer_mask[AES_BYTES-1-r]), // [RULE_06] [RULE_09]
			.ld_data (tbl[xfer_idx][r]),
			.q       (stage[r])
		);
	end

	// full entry image: bytes 0 to 5 come from the neighbouring bank
	always_comb begin
		for (int r = 0; r < AES_UPPER_N; r++) begin
			entry[r] = upper_stage_in[8*r +: 8];
		end
		for (int r = AES_STAGE_BASE; r < AES_BYTES; r++) begin
			entry[r] = stage[r];
		end
	end

	// byte-enable registers; mask bit k selects access byte 15-k
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			be_high <= RST_BYTE;
			be_low  <= RST_BYTE;
		end else if (rb.wr) begin
			if (rb.idx == IDX_BE_HIGH) begin
				be_high <= rb.wdata;
			end
			if (rb.idx == IDX_BE_LOW_GO) begin
				be_low <= rb.wdata;
			end
		end
	end

	// direction and index; the status bits are owned by the engine
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			ctrl_dir <= RST_CTRL_RW[CTRL_DIR];
			ctrl_idx <= RST_CTRL_RW[CTRL_IDX_MSB:0];
		end else if (rb.wr && (rb.idx == IDX_CTRL)) begin
			ctrl_dir <= rb.wdata[CTRL_DIR]; // [RULE_07]
			ctrl_idx <= rb.wdata[CTRL_IDX_MSB:0];
		end
	end

	// transfer engine: latch the request, move bytes in one cycle
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			state     <= AES_ST_IDLE;
			xfer_dir  <= 1'b0;
			xfer_idx  <= 4'h0;
			xfer_mask <= 16'h0000;
		end else if (clk_en) begin
			unique case (state)
				AES_ST_IDLE: begin
					if (trig) begin
						state     <= AES_ST_XFER;
						xfer_dir  <= ctrl_dir;
						xfer_idx  <= ctrl_idx;
						// new low byte joins the stored high byte
						xfer_mask <= {be_high, rb.wdata}; // [RULE_03]
					end
				end
				AES_ST_XFER: begin
					state <= AES_ST_IDLE;
				end
			endcase
		end
	end

	// status: cleared when a transfer of that kind starts, set when done
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			wr_done <= RST_DONE;
			rd_done <= RST_DONE;
		end else if (clk_en) begin
			if (trig && ctrl_dir) begin
				wr_done <= 1'b0; // [RULE_07]
			end else if (in_xfer && xfer_dir) begin
				wr_done <= 1'b1; // [RULE_07]
			end
			if (trig && !ctrl_dir) begin
				rd_done <= 1'b0; // [RULE_08]
			end else if (in_xfer && !xfer_dir) begin
				rd_done <= 1'b1; // [RULE_08]
			end
		end
	end

	// table store; only enabled bytes of the chosen entry change
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			for (int e = 0; e < DEPTH; e++) begin
				for (int b = 0; b < AES_BYTES; b++) begin
					tbl[e][b] <= RST_BYTE;
				end
			end
		end else if (in_xfer && xfer_dir) begin
			for (int b = 0; b < AES_BYTES; b++) begin
				// reversed bit order [RULE_04] [RULE_05]
				if (xfer_mask[AES_BYTES-1-b]) begin
					tbl[xfer_idx][b] <= entry[b]; // [RULE_06] [RULE_09]
				end
			end
		end
	end

	// results for bytes 0 to 5 go out with a one-cycle load pulse
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			upper_stage_out  <= 48'h000000000000;
			upper_stage_load <= 6'h00;
		end else if (clk_en) begin
			upper_stage_load <= 6'h00;
			if (state == AES_ST_XFER && !xfer_dir) begin
				for (int r = 0; r < AES_UPPER_N; r++) begin
					if (xfer_mask[AES_BYTES-1-r]) begin // [RULE_04]
						upper_stage_out[8*r +: 8] <= tbl[xfer_idx][r];
						upper_stage_load[r]       <= 1'b1;
					end
				end
			end
		end
	end

	// register read mux; unused control bit 7 reads zero
	always_comb begin
		rb.rdata = 8'h00;
		for (int r = AES_STAGE_BASE; r < AES_BYTES; r++) begin
			if (rb.idx == IDX_MAC_1 + 12'(r - AES_STAGE_BASE)) begin
				rb.rdata = stage[r];
			end
		end
		if (rb.idx == IDX_BE_HIGH) begin
			rb.rdata = be_high;
		end
		if (rb.idx == IDX_BE_LOW_GO) begin
			rb.rdata = be_low;
		end
		if (rb.idx == IDX_CTRL) begin
			rb.rdata = {1'b0, wr_done, rd_done, ctrl_dir, ctrl_idx};
		end
	end

	// entry fields for the matching logic, registered per lookup index
	assign lk_prio   = tbl[lookup_index][BYTE_PRIO_ACT];
	assign lk_remark = tbl[lookup_index][BYTE_REMARK];
	assign lk_fwd    = tbl[lookup_index][BYTE_FWD];

	// the remark value straddles two bytes, so it is rebuilt here
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			priority_handling_select <= 2'h0;
			remark_priority_enable   <= 1'b0;
			remark_priority          <= 3'h0;
			forward_map_handling     <= 2'h0;
			forward_map              <= 7'h00;
		end else if (clk_en) begin
			priority_handling_select <= lk_prio[PM_MSB:PM_LSB];
			remark_priority_enable   <= lk_prio[RPE_BIT];
			remark_priority          <= {lk_prio[REM_HI_MSB:0],
				lk_remark[REM_LO_BIT]}; // [RULE_01]
			forward_map_handling     <= lk_remark[MM_MSB:MM_LSB];
			forward_map              <= lk_fwd[FWD_MSB:0]; // [RULE_02]
		end
	end

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (reset);

	// remark priority is byte A bits 1:0 above byte B bit 7
	property p_remark_join;
		clk_en |=> remark_priority ==
			{$past(lk_prio[1:0]), $past(lk_remark[7])};
	endproperty
	a_remark_join: assert property (p_remark_join) // [RULE_01]
		else $error("remark priority not assembled from both bytes");

	// forward map bit 0 is port 1, taken unchanged
	property p_fwd_map;
		clk_en |=> forward_map == $past(lk_fwd[6:0]);
	endproperty
	a_fwd_map: assert property (p_fwd_map) // [RULE_02]
		else $error("forward map does not follow the entry");

	// start write latches the whole mask and enters the transfer
	property p_start_mask;
		trig |=> (state == AES_ST_XFER)
			&& (xfer_mask == {$past(be_high), $past(rb.wdata)});
	endproperty
	a_start_mask: assert property (p_start_mask) // [RULE_03]
		else $error("start did not take the full byte-enable mask");

	// high enable bit 0 writes access byte 7
	property p_high_order;
		in_xfer && xfer_dir && xfer_mask[8] |=>
			tbl[xfer_idx][7] == $past(stage[7]);
	endproperty
	a_high_order: assert property (p_high_order) // [RULE_04]
		else $error("high enable bit 0 did not write byte 7");

	// low enable bit 0 writes access byte F
	property p_low_order;
		in_xfer && xfer_dir && xfer_mask[0] |=>
			tbl[xfer_idx][15] == $past(stage[15]);
	endproperty
	a_low_order: assert property (p_low_order) // [RULE_05]
		else $error("low enable bit 0 did not write byte F");

	// enabled byte is loaded by a read
	property p_read_load;
		in_xfer && !xfer_dir && xfer_mask[0] |=>
			stage[15] == $past(tbl[xfer_idx][15]);
	endproperty
	a_read_load: assert property (p_read_load) // [RULE_06]
		else $error("enabled byte not loaded by read");

	// write status low during the write, high one cycle later
	property p_wr_status;
		trig && ctrl_dir |=> !wr_done ##1 (wr_done || !clk_en);
	endproperty
	a_wr_status: assert property (p_wr_status) // [RULE_07]
		else $error("write status sequence wrong");

	// disabled table byte keeps its value on a write
	property p_keep_byte;
		in_xfer && xfer_dir && !xfer_mask[0] |=>
			$stable(tbl[xfer_idx][15]);
	endproperty
	a_keep_byte: assert property (p_keep_byte) // [RULE_09]
		else $error("disabled table byte changed on write");

	// read status low while a table read runs, so polling cannot race it
	property p_rd_status;
		trig && !ctrl_dir |=> !rd_done ##1 (rd_done || !clk_en);
	endproperty
	a_rd_status: assert property (p_rd_status) // [RULE_08]
		else $error("read status sequence wrong");

	// high enable bit 7 hands access byte 0 to the neighbouring bank
	property p_upper_load;
		in_xfer && !xfer_dir && xfer_mask[15] |=> upper_stage_load[0]
			&& (upper_stage_out[7:0] == $past(tbl[xfer_idx][0]));
	endproperty
	a_upper_load: assert property (p_upper_load) // [RULE_04]
		else $error("high enable bit 7 did not load byte 0");

	// a low clock enable freezes the engine, the bus and the fields
	property p_freeze;
		!clk_en |=> $stable(state) && $stable(forward_map)
			&& $stable(hreadyout);
	endproperty
	a_freeze: assert property (p_freeze)
		else $error("state moved while the clock enable was low");
endmodule
`default_nettype wire

/* File: logic/aes_stage_byte.sv */
// one software-writable staging byte that a table read can also load
`timescale 1ns/10ps
`default_nettype none
module aes_stage_byte
	import aes_pkg::*;
#(
	parameter logic [7:0] RESET_VALUE = RST_BYTE
) (
	input  wire logic       clk,
	input  wire logic       reset,
	input  wire logic       clk_en,
	input  wire logic       sw_we,
	input  wire logic [7:0] sw_data,
	input  wire logic       ld_en,
	input  wire logic [7:0] ld_data,
	output logic      [7:0] q
);
	// table load wins: software should not write while a read runs
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			q <= RESET_VALUE;
		end else if (clk_en) begin
			if (ld_en) begin
				q <= ld_data;
			end else if (sw_we) begin
				q <= sw_data;
			end
		end
	end
endmodule
`default_nettype wire

/* File: tb/aes_tb.sv */
// self-checking bench for the acl entry staging register bank
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, exp, got) begin \
	samples_checked++; \
	if ((got) !== (exp)) begin \
		fail_count++; \
		$display("[FAIL] %s expected %h seen %h", nm, exp, got); \
	end \
end
module tb
	import aes_pkg::*;
;
	logic        clk;
	logic        reset;
	logic        clk_en;
	logic        hsel;
	logic [31:0] haddr;
	logic [1:0]  htrans;
	logic        hwrite;
	logic [2:0]  hsize;
	logic        hready;
	logic [31:0] hwdata;
	logic        hreadyout;
	logic        hresp;
	logic [31:0] hrdata;
	logic [47:0] upper_stage_in;
	logic [47:0] upper_stage_out;
	logic [5:0]  upper_stage_load;
	logic [3:0]  lookup_index;
	logic [1:0]  priority_handling_select;
	logic        remark_priority_enable;
	logic [2:0]  remark_priority;
	logic [1:0]  forward_map_handling;
	logic [6:0]  forward_map;
	int          fail_count;
	int          samples_checked;
	int          cycles;
	logic [7:0]  stg [16];
	logic [7:0]  tblv [16];
	logic [5:0]  seen_load;
	logic [47:0] cap_out;
	localparam logic [7:0] PAT [10] = '{8'h12, 8'h34, 8'h56, 8'h78, 8'hc7,
		8'ha0, 8'h5a, 8'h85, 8'h9b, 8'hde};

	// single slave, so its own ready is the bus ready
	assign hready = hreadyout;

	aes_regs u_dut (
		.clk                      (clk),
		.reset                    (reset),
		.clk_en                   (clk_en),
		.hsel                     (hsel),
		.haddr                    (haddr),
		.htrans                   (htrans),
		.hwrite                   (hwrite),
		.hsize                    (hsize),
		.hready                   (hready),
		.hwdata                   (hwdata),
		.hreadyout                (hreadyout),
		.hresp                    (hresp),
		.hrdata                   (hrdata),
		.upper_stage_in           (upper_stage_in),
		.upper_stage_out          (upper_stage_out),
		.upper_stage_load         (upper_stage_load),
		.lookup_index             (lookup_index),
		.priority_handling_select (priority_handling_select),
		.remark_priority_enable   (remark_priority_enable),
		.remark_priority          (remark_priority),
		.forward_map_handling     (forward_map_handling),
		.forward_map              (forward_map)
	);

	// 40 MHz clock
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	// hang guard; the whole run needs a few hundred cycles
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			fail_count++;
			conclude();
		end
	end

	// the load pulse lasts one cycle, so it is caught here and not polled
	always @(posedge clk) begin
		if (upper_stage_load !== 6'h00) begin
			seen_load <= seen_load | upper_stage_load;
			cap_out <= upper_stage_out;
		end
	end

	task automatic conclude();
		$display("checks %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// address phase held until ready is sampled high
	task automatic bus_addr(input logic [11:0] idx, input logic wr);
		@(posedge clk);
		haddr <= {18'h0, idx, 2'b00};
		htrans <= 2'b10;
		hwrite <= wr;
		do @(posedge clk); while (hready !== 1'b1);
		htrans <= 2'b00;
	endtask

	task automatic bus_write(input logic [11:0] idx, input logic [7:0] d);
		bus_addr(idx, 1'b1);
		hwdata <= {24'h0, d};
		do @(posedge clk); while (hready !== 1'b1);
	endtask

	task automatic rd_chk(input logic [11:0] idx, input logic [31:0] exp);
		bus_addr(idx, 1'b0);
		do @(posedge clk); while (hready !== 1'b1);
		`CHK($sformatf("reg %h", idx), exp, hrdata)
		`CHK("hresp", 1'b0, hresp)
	endtask

	task automatic fill(input logic [7:0] v);
		for (int i = 6; i < 16; i++) begin
			stg[i] = v;
			bus_write(12'(IDX_MAC_1 + i - 6), v);
		end
	endtask

	// one table transfer on entry 3, then the status and, for a read, every visible effect compared
	task automatic tbl_op(input logic dir, input logic [7:0] beh,
		input logic [7:0] bel);
		logic s;
		bus_write(IDX_CTRL, {3'b111, dir, 4'h3});
		bus_write(IDX_BE_HIGH, beh);
		seen_load = 6'h00;
		bus_write(IDX_BE_LOW_GO, bel);
		rd_chk(IDX_CTRL, {25'h0, 2'b11, dir, 4'h3});
		for (int i = 0; i < 16; i++) begin
			s = (i < 8) ? beh[7 - i] : bel[15 - i];
			if (dir && s)
				tblv[i] = (i < 6) ? upper_stage_in[8 * i +: 8] : stg[i];
			else if (!dir && i >= 6) begin
				if (s)
					stg[i] = tblv[i];
				rd_chk(12'(IDX_MAC_1 + i - 6), {24'h0, stg[i]});
			end else if (!dir) begin
				`CHK("load", s, seen_load[i])
				if (s)
					`CHK("out", tblv[i], cap_out[8 * i +: 8])
			end
		end
	endtask

	// field outputs follow the looked-up entry one cycle later
	task automatic look_chk(input logic [3:0] ix);
		logic [7:0] a;
		logic [7:0] b;
		logic [7:0] d;
		a = (ix == 4'h3) ? tblv[BYTE_PRIO_ACT] : 8'h00;
		b = (ix == 4'h3) ? tblv[BYTE_REMARK] : 8'h00;
		d = (ix == 4'h3) ? tblv[BYTE_FWD] : 8'h00;
		@(posedge clk);
		lookup_index <= ix;
		repeat (2) @(posedge clk);
		`CHK("pm", a[7:6], priority_handling_select)
		`CHK("rpe", a[2], remark_priority_enable)
		`CHK("remark", {a[1:0], b[7]}, remark_priority)
		`CHK("mm", b[6:5], forward_map_handling)
		`CHK("fwd", d[6:0], forward_map)
	endtask

	initial begin
		clk_en = 1'b1;
		hsel = 1'b1;
		haddr = 32'h0;
		htrans = 2'b00;
		hwrite = 1'b0;
		hsize = 3'b010;
		hwdata = 32'h0;
		upper_stage_in = 48'h0;
		lookup_index = 4'h0;
		reset = 1'b1;
		fail_count = 0;
		samples_checked = 0;
		cycles = 0;
		seen_load = 6'h00;
		cap_out = 48'h0;
		for (int i = 0; i < 16; i++) begin
			stg[i] = 8'h00;
			tblv[i] = 8'h00;
		end
		repeat (10) @(posedge clk);
		reset <= 1'b0;
		// reset values, then the unmapped places on either side
		for (int i = 0; i < 12; i++)
			rd_chk(12'(IDX_MAC_1 + i), 32'h0);
		rd_chk(IDX_CTRL, 32'h60);
		rd_chk(12'h605, 32'h0);
		bus_write(12'h613, 8'hff);
		rd_chk(12'h613, 32'h0);
		// staging bytes, spare included, read back as written
		for (int i = 0; i < 10; i++) begin
			stg[6 + i] = PAT[i];
			bus_write(12'(IDX_MAC_1 + i), PAT[i]);
		end
		for (int i = 0; i < 10; i++)
			rd_chk(12'(IDX_MAC_1 + i), {24'h0, PAT[i]});
		look_chk(4'h3);
		upper_stage_in <= 48'habcdef012345;
		tbl_op(1'b1, 8'hff, 8'hff);
		look_chk(4'h3);
		look_chk(4'h4);
		fill(8'hee);
		tbl_op(1'b0, 8'hff, 8'hff);
		fill(8'hee);
		tbl_op(1'b0, 8'h82, 8'h24);
		// partial write: only the forward byte may change in the table
		stg[10] = 8'h00;
		bus_write(IDX_PRIO_ACT, 8'h00);
		stg[13] = 8'h7f;
		bus_write(IDX_FWD_PORTS, 8'h7f);
		upper_stage_in <= 48'h0;
		tbl_op(1'b1, 8'h00, 8'h04);
		look_chk(4'h3);
		// a low clock enable holds the forward map and ready where they stand
		@(posedge clk);
		clk_en <= 1'b0;
		lookup_index <= 4'h4;
		repeat (3) @(posedge clk);
		`CHK("frozen fwd", 7'h7f, forward_map)
		`CHK("frozen ready", 1'b1, hreadyout)
		clk_en <= 1'b1;
		look_chk(4'h4);
		fill(8'h11);
		tbl_op(1'b0, 8'hff, 8'hff);
		// a second reset clears staging and the table again and sets both status bits high
		@(posedge clk);
		reset <= 1'b1;
		repeat (2) @(posedge clk);
		reset <= 1'b0;
		for (int i = 0; i < 16; i++)
			tblv[i] = 8'h00;
		rd_chk(IDX_CTRL, 32'h60);
		rd_chk(IDX_RULESET_LO, 32'h0);
		look_chk(4'h3);
		conclude();
	end
endmodule
`default_nettype wire
